// file: design/serial_master_params.svh
// constants for the slotted serial master: commands, timing counts, sizes
`ifndef SERIAL_MASTER_PARAMS_SVH
`define SERIAL_MASTER_PARAMS_SVH
`define CLK_FREQ_KHZ 40000
`define BIT_RATE_KBPS 1000
`define HALF_BIT_CYCLES ((`CLK_FREQ_KHZ / `BIT_RATE_KBPS) / 2)
`define TICK_DIVIDE 128
`define SLOT_TIME_US 1000
`define TIMEOUT_TIME_US 10
`define TICK_PERIOD_NS ((`TICK_DIVIDE * 1000000) / `CLK_FREQ_KHZ)
`define SLOT_TICKS ((`SLOT_TIME_US * 1000) / `TICK_PERIOD_NS)
`define TIMEOUT_TICKS ((`TIMEOUT_TIME_US * 1000) / `TICK_PERIOD_NS)
`define CHAR_BITS 8
`define CMD_STATUS 8'h00
`define CMD_RECEIVE 2'h1
`define CMD_TRANSMIT 2'h2
`define CMD_EXCHANGE 2'h3
`define REPLY_TX_COUNT 2'h1
`define BUFFER_SIZE 6'h08
`endif

// file: design/serial_master_pkg.sv
// types for the slotted serial master
package serial_master_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_SELECT_WAIT = 4'h1,
      ST_CMD = 4'h2,
      ST_CMD_WAIT = 4'h3,
      ST_DATA = 4'h4,
      ST_SLOT_END = 4'h5,
      ST_SWITCH = 4'h6
   } seq_state_e;
   typedef enum logic [1:0] {
      SLOT_STATUS = 2'h0,
      SLOT_TX = 2'h1,
      SLOT_XCHG = 2'h2,
      SLOT_RX = 2'h3
   } slot_kind_e;
endpackage

// file: design/char_shifter.sv
// one-character serial shifter: type 1 phase, msb first, eight bits
`timescale 1ns/1ps
`default_nettype none
`include "serial_master_params.svh"
module char_shifter
   import serial_master_pkg::*;
#(
   parameter int HALF_BIT = `HALF_BIT_CYCLES
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // character request
   input wire logic i_start,
   input wire logic [7:0] i_tx_byte,
   output logic o_busy,
   output logic o_done,
   output logic [7:0] o_rx_byte,
   // serial pins
   output logic o_shift_clock_out,
   output logic o_serial_data_out,
   input wire logic i_serial_data_in
);
   typedef struct packed {
      logic active;
      logic [7:0] shreg;
      logic [7:0] rx;
      logic [3:0] bits;
      logic [15:0] div;
      logic sck;
      logic sdo;
      logic done;
   } shift_s;
   shift_s state_reg;
   shift_s state_next;

   // type 1: data out on falling edge, sampled on rising edge, clock idles high
   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      if (!state_reg.active) begin
         if (i_start) begin
            state_next.active = 1'b1;
            state_next.shreg = {i_tx_byte[6:0], 1'b0};
            state_next.sdo = i_tx_byte[7];
            state_next.bits = 4'h0;
            state_next.div = 16'h0000;
            state_next.sck = 1'b1;
         end
      end else if (state_reg.div == 16'(HALF_BIT - 1)) begin
         state_next.div = 16'h0000;
         if (state_reg.sck) begin
            // falling edge: next bit out; the first bit already stands from the start
            state_next.sck = 1'b0;
            if (state_reg.bits != 4'h0) begin
               state_next.sdo = state_reg.shreg[7];
               state_next.shreg = {state_reg.shreg[6:0], 1'b0};
            end
         end else begin
            // rising edge: sample msb-first; data out holds so the slave sees it settled
            state_next.sck = 1'b1;
            state_next.rx = {state_reg.rx[6:0], i_serial_data_in};
            if (state_reg.bits == 4'(`CHAR_BITS - 1)) begin
               state_next.active = 1'b0;
               state_next.done = 1'b1;
            end else begin
               state_next.bits = state_reg.bits + 4'h1;
            end
         end
      end else begin
         state_next.div = state_reg.div + 16'h0001;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= '{active: 1'b0, shreg: 8'h00, rx: 8'h00, bits: 4'h0,
                        div: 16'h0000, sck: 1'b1, sdo: 1'b1, done: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_busy = state_reg.active;
   assign o_done = state_reg.done;
   assign o_rx_byte = state_reg.rx;
   assign o_shift_clock_out = state_reg.sck;
   assign o_serial_data_out = state_reg.sdo;
endmodule
`default_nettype wire

// file: design/slot_sequencer.sv
// slotted serial master: status, transmit, exchange and receive slots on two slaves
`timescale 1ns/1ps
`default_nettype none
`include "serial_master_params.svh"
module slot_sequencer
   import serial_master_pkg::*;
#(
   parameter int TICK_DIV = `TICK_DIVIDE,
   parameter int SLOT_TICKS = `SLOT_TICKS,
   parameter int TIMEOUT_TICKS = `TIMEOUT_TICKS,
   parameter logic [5:0] BUF_SIZE = `BUFFER_SIZE
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // serial link
   output logic o_shift_clock_out,
   output logic o_serial_data_out,
   input wire logic i_serial_data_in,
   // slave selection and handshake
   output logic o_slave_a_select_n,
   output logic o_slave_b_select_n,
   input wire logic i_slave_busy,
   // status
   output logic o_char_done_event,
   output logic o_slot_tick_event,
   output logic o_target_slave_flag,
   output logic [5:0] o_data_count,
   output logic o_slave_can_send,
   output logic o_timeout_event,
   output logic o_mismatch_event,
   output logic [7:0] o_error_count,
   output logic o_seq_done_event
);
   localparam int DIV_W = $clog2(TICK_DIV);

   typedef struct packed {
      seq_state_e st;
      slot_kind_e slot;
      logic [DIV_W-1:0] prediv;
      logic [15:0] slot_cnt;
      logic [15:0] to_cnt;
      logic flag;
      logic sel_a_n;
      logic sel_b_n;
      logic [5:0] count;
      logic [5:0] idx;
      logic can_send;
      logic [7:0] tx_base;
      logic [7:0] exp_base;
      logic start;
      logic [7:0] tx_byte;
      logic timeout_ev;
      logic mismatch_ev;
      logic [7:0] errors;
      logic done_ev;
   } seq_s;
   seq_s state_reg;
   seq_s state_next;

   logic char_busy;
   logic char_done;
   logic [7:0] rx_byte;
   logic tick;
   logic slot_tick;
   logic to_expired;

   // smaller of the reported count and the local buffer size
   function automatic logic [5:0] clamp_count(input logic [5:0] reported);
      clamp_count = (reported < BUF_SIZE) ? reported : BUF_SIZE;
   endfunction

   // command byte for a slot: kind in the top bits, count below; the status slot sends 00 without the count
   function automatic logic [7:0] slot_command(input slot_kind_e kind, input logic [5:0] n);
      case (kind)
         SLOT_TX: slot_command = {`CMD_TRANSMIT, n};
         SLOT_XCHG: slot_command = {`CMD_EXCHANGE, n};
         SLOT_RX: slot_command = {`CMD_RECEIVE, n};
         default: slot_command = `CMD_STATUS;
      endcase
   endfunction

   char_shifter #(
      .HALF_BIT(`HALF_BIT_CYCLES)
   ) u_shifter (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_start(state_reg.start),
      .i_tx_byte(state_reg.tx_byte),
      .o_busy(char_busy),
      .o_done(char_done),
      .o_rx_byte(rx_byte),
      .o_shift_clock_out(o_shift_clock_out),
      .o_serial_data_out(o_serial_data_out),
      .i_serial_data_in(i_serial_data_in)
   );

   // timer enables: prescaler wrap, slot wrap and timeout reach
   assign tick = (state_reg.prediv == DIV_W'(TICK_DIV - 1));
   assign slot_tick = tick && (state_reg.slot_cnt == 16'(SLOT_TICKS - 1));
   assign to_expired = (state_reg.to_cnt >= 16'(TIMEOUT_TICKS));

   always_comb begin
      state_next = state_reg;
      state_next.start = 1'b0;
      state_next.timeout_ev = 1'b0;
      state_next.mismatch_ev = 1'b0;
      state_next.done_ev = 1'b0;
      // free-running prescaler and slot interval counter
      state_next.prediv = tick ? '0 : state_reg.prediv + 1'b1;
      if (tick) begin
         state_next.slot_cnt = slot_tick ? 16'h0000 : state_reg.slot_cnt + 16'h0001;
      end
      // timeout counter runs in busy-wait states only
      if ((state_reg.st == ST_SELECT_WAIT) || (state_reg.st == ST_CMD_WAIT)) begin
         if (tick) begin
            state_next.to_cnt = state_reg.to_cnt + 16'h0001;
         end
      end else begin
         state_next.to_cnt = 16'h0000;
      end

      case (state_reg.st)
         ST_IDLE: begin
            if (slot_tick) begin
               // one select low at a time, chosen by the flag
               state_next.sel_a_n = state_reg.flag;
               state_next.sel_b_n = ~state_reg.flag;
               state_next.to_cnt = 16'h0000;
               state_next.st = ST_SELECT_WAIT;
            end
         end
         ST_SELECT_WAIT: begin
            if (!i_slave_busy) begin
               state_next.tx_byte = slot_command(state_reg.slot, state_reg.count);
               state_next.start = 1'b1;
               state_next.st = ST_CMD;
            end else if (to_expired) begin
               state_next.timeout_ev = 1'b1;
               state_next.st = ST_SWITCH;
            end
         end
         ST_CMD: begin
            if (char_done) begin
               state_next.st = ST_CMD_WAIT;
            end
         end
         ST_CMD_WAIT: begin
            if (!i_slave_busy) begin
               state_next.idx = 6'h00;
               if (state_reg.slot != SLOT_STATUS && state_reg.count == 6'h00) begin
                  state_next.st = ST_SLOT_END;
               end else begin
                  state_next.tx_byte = state_reg.tx_base;
                  state_next.start = 1'b1;
                  state_next.st = ST_DATA;
               end
            end else if (to_expired) begin
               state_next.timeout_ev = 1'b1;
               state_next.st = ST_SWITCH;
            end
         end
         ST_DATA: begin
            if (char_done) begin
               case (state_reg.slot)
                  SLOT_STATUS: begin
                     // reply: top bits tell direction, low six bits the count
                     state_next.count = clamp_count(rx_byte[5:0]);
                     state_next.can_send = (rx_byte[7:6] == `REPLY_TX_COUNT);
                  end
                  SLOT_XCHG: begin
                     // slave echoes complement of last slot's pattern
                     if (rx_byte != ~(state_reg.exp_base + {2'h0, state_reg.idx})) begin
                        state_next.mismatch_ev = 1'b1;
                        state_next.errors = state_reg.errors + 8'h01;
                     end
                  end
                  SLOT_RX: begin
                     if (rx_byte != ~(state_reg.exp_base + {2'h0, state_reg.idx})) begin
                        state_next.mismatch_ev = 1'b1;
                        state_next.errors = state_reg.errors + 8'h01;
                     end
                  end
                  default: begin
                  end
               endcase
               if (state_reg.slot == SLOT_STATUS ||
                   state_reg.idx + 6'h01 >= state_reg.count) begin
                  state_next.st = ST_SLOT_END;
               end else begin
                  state_next.idx = state_reg.idx + 6'h01;
                  // increment pattern: base plus character index
                  state_next.tx_byte = state_reg.tx_base + {2'h0, state_reg.idx} + 8'h01;
                  state_next.start = 1'b1;
               end
            end
         end
         ST_SLOT_END: begin
            // deselect both slaves, then prepare next slot
            state_next.sel_a_n = 1'b1;
            state_next.sel_b_n = 1'b1;
            state_next.st = ST_IDLE;
            case (state_reg.slot)
               SLOT_STATUS: state_next.slot = SLOT_TX;
               SLOT_TX: begin
                  // expected echo is the just-sent pattern; next pattern follows on
                  state_next.exp_base = state_reg.tx_base;
                  state_next.tx_base = state_reg.tx_base + {2'h0, state_reg.count};
                  state_next.slot = SLOT_XCHG;
               end
               SLOT_XCHG: begin
                  state_next.exp_base = state_reg.tx_base;
                  state_next.tx_base = state_reg.tx_base + {2'h0, state_reg.count};
                  state_next.slot = SLOT_RX;
               end
               default: begin
                  state_next.st = ST_SWITCH;
               end
            endcase
         end
         ST_SWITCH: begin
            state_next.sel_a_n = 1'b1;
            state_next.sel_b_n = 1'b1;
            state_next.flag = ~state_reg.flag;
            state_next.slot = SLOT_STATUS;
            state_next.done_ev = 1'b1;
            state_next.st = ST_IDLE;
         end
         default: begin
            state_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= '{st: ST_IDLE, slot: SLOT_STATUS, prediv: '0, slot_cnt: 16'h0000,
                        to_cnt: 16'h0000, flag: 1'b0, sel_a_n: 1'b1, sel_b_n: 1'b1,
                        count: 6'h00, idx: 6'h00, can_send: 1'b0, tx_base: 8'h00,
                        exp_base: 8'h00, start: 1'b0, tx_byte: 8'h00, timeout_ev: 1'b0,
                        mismatch_ev: 1'b0, errors: 8'h00, done_ev: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from state except the slot tick, decoded from the prescaler and slot counter, and char done, taken from the shifter
   assign o_slave_a_select_n = state_reg.sel_a_n;
   assign o_slave_b_select_n = state_reg.sel_b_n;
   assign o_char_done_event = char_done;
   assign o_slot_tick_event = slot_tick;
   assign o_target_slave_flag = state_reg.flag;
   assign o_data_count = state_reg.count;
   assign o_slave_can_send = state_reg.can_send;
   assign o_timeout_event = state_reg.timeout_ev;
   assign o_mismatch_event = state_reg.mismatch_ev;
   assign o_error_count = state_reg.errors;
   assign o_seq_done_event = state_reg.done_ev;
endmodule
`default_nettype wire

// file: testbench/slot_sequencer_properties.sv
// port checker for the slotted serial master
`timescale 1ns/1ps
`default_nettype none
`include "serial_master_params.svh"
module slot_sequencer_properties #(
   parameter int TICK_DIV = 128,
   parameter int SLOT_TICKS = 312,
   parameter logic [5:0] BUF_SIZE = 6'h08
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // link and selects
   input wire logic o_shift_clock_out,
   input wire logic o_slave_a_select_n,
   input wire logic o_slave_b_select_n,
   // status
   input wire logic o_char_done_event,
   input wire logic o_slot_tick_event,
   input wire logic o_target_slave_flag,
   input wire logic [5:0] o_data_count,
   input wire logic o_timeout_event,
   input wire logic o_mismatch_event,
   input wire logic [7:0] o_error_count,
   input wire logic o_seq_done_event
);
   localparam int PERIOD = TICK_DIV * SLOT_TICKS;
   localparam int HALF = `HALF_BIT_CYCLES;
   logic sclk_q;
   logic seen_tick;
   logic rising;
   logic [5:0] low_cnt;
   logic [3:0] rise_cnt;
   int tick_cnt;
   assign rising = o_shift_clock_out && !sclk_q;
   // counters instead of long repetitions, which would slow the tools badly
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sclk_q <= 1'b1;
         seen_tick <= 1'b0;
         low_cnt <= 6'h00;
         rise_cnt <= 4'h0;
         tick_cnt <= 0;
      end else begin
         sclk_q <= o_shift_clock_out;
         low_cnt <= o_shift_clock_out ? 6'h00 : low_cnt + 6'h01;
         rise_cnt <= o_char_done_event ? 4'h0 : rise_cnt + {3'h0, rising};
         tick_cnt <= o_slot_tick_event ? 0 : tick_cnt + 1;
         if (o_slot_tick_event) seen_tick <= 1'b1;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   property p_one_select;
      !(!o_slave_a_select_n && !o_slave_b_select_n);
   endproperty
   a_one_select: assert property (p_one_select) else $error("both selects low");
   property p_idle_clock;
      (o_slave_a_select_n && o_slave_b_select_n) |-> o_shift_clock_out;
   endproperty
   a_idle_clock: assert property (p_idle_clock) else $error("clock moves unselected");
   property p_sel_a;
      $fell(o_slave_a_select_n) |-> $past(o_slot_tick_event) && !o_target_slave_flag;
   endproperty
   a_sel_a: assert property (p_sel_a) else $error("bad select of slave a");
   property p_sel_b;
      $fell(o_slave_b_select_n) |-> $past(o_slot_tick_event) && o_target_slave_flag;
   endproperty
   a_sel_b: assert property (p_sel_b) else $error("bad select of slave b");
   property p_tick_period;
      (o_slot_tick_event && seen_tick) |-> tick_cnt == PERIOD - 1;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("slot period");
   property p_half_bit;
      rising |-> low_cnt == HALF;
   endproperty
   a_half_bit: assert property (p_half_bit) else $error("bit rate");
   property p_char_bits;
      o_char_done_event |-> rise_cnt + rising == 8;
   endproperty
   a_char_bits: assert property (p_char_bits) else $error("char length");
   property p_timeout_release;
      o_timeout_event |-> ##[0:2] (o_slave_a_select_n && o_slave_b_select_n);
   endproperty
   a_timeout_release: assert property (p_timeout_release) else $error("no deselect");
   property p_flag_toggle;
      $changed(o_target_slave_flag) |-> o_seq_done_event || $past(o_seq_done_event);
   endproperty
   a_flag_toggle: assert property (p_flag_toggle) else $error("stray flag change");
   property p_err_step;
      $changed(o_error_count) |-> o_error_count == $past(o_error_count) + 8'h01;
   endproperty
   a_err_step: assert property (p_err_step) else $error("error count step");
   property p_count_cap;
      o_data_count <= BUF_SIZE;
   endproperty
   a_count_cap: assert property (p_count_cap) else $error("count above buffer");
   c_timeout: cover property (o_timeout_event);
   c_mismatch: cover property (o_mismatch_event);
   c_seq_done: cover property (o_seq_done_event);
endmodule
bind slot_sequencer slot_sequencer_properties #(.TICK_DIV(TICK_DIV), .SLOT_TICKS(SLOT_TICKS),
   .BUF_SIZE(BUF_SIZE)) i_props (.i_clock(i_clock), .i_arst_n(i_arst_n),
   .o_shift_clock_out(o_shift_clock_out), .o_slave_a_select_n(o_slave_a_select_n),
   .o_slave_b_select_n(o_slave_b_select_n), .o_char_done_event(o_char_done_event),
   .o_slot_tick_event(o_slot_tick_event), .o_target_slave_flag(o_target_slave_flag),
   .o_data_count(o_data_count), .o_timeout_event(o_timeout_event),
   .o_mismatch_event(o_mismatch_event), .o_error_count(o_error_count),
   .o_seq_done_event(o_seq_done_event));
`default_nettype wire

// file: testbench/slave_pair_model.sv
// behavioural model of the two slaves with busy handshake
`timescale 1ns/1ps
`default_nettype none
module slave_pair_model (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // link from the master
   input wire logic i_sel_a_n,
   input wire logic i_sel_b_n,
   input wire logic i_sclk,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_busy,
   // scenario controls
   input wire logic [7:0] i_delay,
   input wire logic i_stall,
   input wire logic i_corrupt,
   input wire logic [7:0] i_reply,
   // command log
   output logic [7:0] o_cmd,
   output logic o_cmd_valid
);
   logic sel;
   logic sclk_q;
   logic [2:0] bits;
   logic [5:0] chars;
   logic [7:0] cnt, sh_in, sh_out, cmd, load;
   logic [7:0] mem [0:63];
   assign sel = !i_sel_a_n || !i_sel_b_n;
   // ready once the delay runs out after select or after each character; stall never readies
   assign o_busy = !sel || i_stall || (cnt < i_delay);
   // next outgoing byte: status reply, filler, or complement of what came in
   always_comb begin
      if (chars == 6'h00) load = 8'hA5;
      else if (cmd == 8'h00) load = i_reply;
      else if (cmd[7:6] == 2'h2) load = 8'h3C;
      else load = ~mem[chars - 6'h01] ^ {7'h00, i_corrupt};
   end
   // data changes on the falling clock and is taken on the rising one
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sclk_q <= 1'b1;
         bits <= 3'h0;
         chars <= 6'h00;
         cnt <= 8'h00;
         cmd <= 8'h00;
         o_miso <= 1'b1;
         o_cmd <= 8'h00;
         o_cmd_valid <= 1'b0;
      end else begin
         sclk_q <= i_sclk;
         o_cmd_valid <= 1'b0;
         if (!sel) begin
            bits <= 3'h0;
            chars <= 6'h00;
            cnt <= 8'h00;
            o_miso <= ~o_miso; // released line shows no stale bit
         end else begin
            if (cnt < i_delay) cnt <= cnt + 8'h01;
            if (sclk_q && !i_sclk) begin
               o_miso <= (bits == 3'h0) ? load[7] : sh_out[7];
               sh_out <= (bits == 3'h0) ? {load[6:0], 1'b0} : {sh_out[6:0], 1'b0};
            end
            if (!sclk_q && i_sclk) begin
               sh_in <= {sh_in[6:0], i_mosi};
               bits <= bits + 3'h1;
               if (bits == 3'h7) begin
                  chars <= chars + 6'h01;
                  cnt <= 8'h00;
                  if (chars == 6'h00) begin
                     cmd <= {sh_in[6:0], i_mosi};
                     o_cmd <= {sh_in[6:0], i_mosi};
                     o_cmd_valid <= 1'b1;
                  end else if (cmd[7]) mem[chars - 6'h01] <= {sh_in[6:0], i_mosi};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/slot_sequencer_tb_top.sv
// testbench: slotted serial master against the two-slave model
`timescale 1ns/1ps
`default_nettype none
module slot_sequencer_tb_top;
   import serial_master_pkg::*;
   logic i_clock, i_arst_n, sclk, mosi, miso, sel_a_n, sel_b_n, busy, char_done, tick;
   logic flag, can_send, tmo, mis, seq_done, cmd_valid, stall, corrupt;
   logic [5:0] count;
   logic [7:0] err, delay, reply, cmd;
   logic [7:0] cmds [$];
   int fail_count, cmp_count, tmo_seen, mis_seen;
   slot_sequencer #(.SLOT_TICKS(26)) i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
      .o_shift_clock_out(sclk), .o_serial_data_out(mosi), .i_serial_data_in(miso),
      .o_slave_a_select_n(sel_a_n), .o_slave_b_select_n(sel_b_n), .i_slave_busy(busy),
      .o_char_done_event(char_done), .o_slot_tick_event(tick), .o_target_slave_flag(flag),
      .o_data_count(count), .o_slave_can_send(can_send), .o_timeout_event(tmo),
      .o_mismatch_event(mis), .o_error_count(err), .o_seq_done_event(seq_done));
   slave_pair_model i_model (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sel_a_n(sel_a_n),
      .i_sel_b_n(sel_b_n), .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso), .o_busy(busy),
      .i_delay(delay), .i_stall(stall), .i_corrupt(corrupt), .i_reply(reply),
      .o_cmd(cmd), .o_cmd_valid(cmd_valid));
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   // log commands seen by the slaves and timeout pulses
   always @(posedge i_clock) begin
      if (cmd_valid === 1'b1) cmds.push_back(cmd);
      if (tmo === 1'b1) tmo_seen++;
      if (mis === 1'b1) mis_seen++;
   end
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // bounded wait for the end of a sequence, then one edge for the flag
   task automatic wait_seq();
      int n;
      n = 0;
      while (seq_done !== 1'b1 && n < 20000) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      if (n >= 20000) begin
         fail_count++;
         $display("wrong value at %0t ns: sequence hung", $time);
         complete_run();
      end
      @(posedge i_clock);
      #1;
   endtask
   task automatic run_seq(input logic [7:0] rv, input logic cv, input logic [5:0] n,
                          input logic [7:0] de);
      logic old_flag;
      logic [7:0] old_err;
      @(posedge i_clock);
      reply <= rv;
      corrupt <= cv;
      cmds.delete();
      #1;
      old_flag = flag;
      old_err = err;
      mis_seen = 0;
      wait_seq();
      check(count === n, "agreed count");
      check(can_send === (rv[7:6] == 2'h1), "reply direction");
      check(mis_seen == de, "mismatch pulses");
      check(flag === ~old_flag, "target flag");
      check(err === old_err + de, "error count");
      check(cmds.size() == 4, "command count");
      if (cmds.size() == 4) begin
         check(cmds[0] === 8'h00, "status command");
         check(cmds[1] === {2'h2, n}, "transmit command");
         check(cmds[2] === {2'h3, n}, "exchange command");
         check(cmds[3] === {2'h1, n}, "receive command");
      end
   endtask
   task automatic t_reset();
      #1;
      check(sel_a_n === 1'b1 && sel_b_n === 1'b1, "selects in reset");
      check(flag === 1'b0 && count === 6'h00 && err === 8'h00, "reset state");
   endtask
   // reply larger than the buffer is clamped; slave a
   task automatic t_clamp();
      run_seq(8'h4A, 1'b0, 6'h08, 8'h00);
   endtask
   // small receivable count on slave b
   task automatic t_small();
      run_seq(8'h03, 1'b0, 6'h03, 8'h00);
   endtask
   // slave returns a wrong bit in each data byte of exchange and receive
   task automatic t_corrupt();
      run_seq(8'h42, 1'b1, 6'h02, 8'h04);
   endtask
   // slave never readies: abort, no command, count kept
   task automatic t_timeout();
      logic old_flag;
      @(posedge i_clock);
      stall <= 1'b1;
      corrupt <= 1'b0;
      cmds.delete();
      tmo_seen = 0;
      #1;
      old_flag = flag;
      wait_seq();
      check(tmo_seen == 1, "timeout pulse");
      check(cmds.size() == 0, "command after timeout");
      check(flag === ~old_flag, "flag after timeout");
      check(count === 6'h02, "count kept");
      stall <= 1'b0;
   endtask
   initial begin
      i_arst_n = 1'b0;
      delay = 8'h06;
      stall = 1'b0;
      corrupt = 1'b0;
      reply = 8'h00;
      fail_count = 0;
      cmp_count = 0;
      repeat (8) @(posedge i_clock);
      t_reset();
      @(posedge i_clock);
      i_arst_n <= 1'b1;
      t_clamp();
      t_small();
      t_corrupt();
      t_timeout();
      complete_run();
   end
endmodule
`default_nettype wire
